// [hdl/ufl_ctrl.sv]
`timescale 1ns/100ps
// Contract
// - Setup bit 0 enables fifo mode, resets zero
// - Setup bit 1 flushes receive fifo, self-clears
// - Setup bit 2 flushes transmit fifo, self-clears
// - Enhanced transmit trigger 16, 32, 64, 112
// - Receive trigger 1/4/8/14 or 15/31/63/111
// - Format bit 6 forces line to space
// - Format bit 7 selects divisor register bank
module ufl_ctrl
    import ufl_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register window, same clock domain
    input wire logic [2:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_rd_hit,
    // Mode from the special function logic
    input wire logic i_enhanced,
    // Fifo control
    input wire logic i_rx_flush_done,
    input wire logic i_tx_flush_done,
    output logic o_fifo_en,
    output logic o_rx_flush,
    output logic o_tx_flush,
    output logic [6:0] o_tx_trig,
    output logic [6:0] o_rx_trig,
    // Character format
    output logic [3:0] o_data_bits,
    output ufl_stop_t o_stop,
    output logic o_parity_en,
    output ufl_parity_t o_parity,
    output logic o_bank_divisor,
    // Serial line
    input wire logic i_txd_raw,
    output logic o_txd
);
    import ufl_pkg::*;

    logic [7:0] character_format_register;
    logic fifo_wr;
    logic format_wr;
    logic [1:0] tx_trig_code;
    logic [1:0] rx_trig_code;
    logic rx_flush_req;
    logic tx_flush_req;
    logic [1:0] next_len;

    // Setup shares offset 2 with the sample clock register while banked
    assign fifo_wr = i_wr && (i_addr == OFS_FIFO_SETUP) && !character_format_register[CF_BANK];
    assign format_wr = i_wr && (i_addr == OFS_CHAR_FORMAT);
    // Writing zero to a flush bit does nothing
    assign rx_flush_req = fifo_wr && i_wdata[FS_RX_FLUSH];
    assign tx_flush_req = fifo_wr && i_wdata[FS_TX_FLUSH];

    // Fifo mode and trigger codes
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_fifo_en <= RST_FIFO_EN;
            tx_trig_code <= RST_TX_TRIG;
            rx_trig_code <= RST_RX_TRIG;
        end else if (fifo_wr) begin
            o_fifo_en <= i_wdata[FS_FIFO_EN];
            tx_trig_code <= i_wdata[FS_TX_TRIG_LO +: 2];
            rx_trig_code <= i_wdata[FS_RX_TRIG_LO +: 2];
        end
    end

    // Flush bits stay high until the fifo reports it is empty
    ufl_flush u_rx_flush (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_req(rx_flush_req),
        .i_done(i_rx_flush_done),
        .o_busy(o_rx_flush)
    );
    ufl_flush u_tx_flush (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_req(tx_flush_req),
        .i_done(i_tx_flush_done),
        .o_busy(o_tx_flush)
    );

    // The receive threshold follows the mode line at the next edge, so a mode change needs no rewrite
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_tx_trig <= TX_TRIG_ENH[RST_TX_TRIG];
            o_rx_trig <= RX_TRIG_STD[RST_RX_TRIG];
        end else begin
            o_tx_trig <= TX_TRIG_ENH[tx_trig_code];
            o_rx_trig <= i_enhanced ? RX_TRIG_ENH[rx_trig_code]
                                    : RX_TRIG_STD[rx_trig_code];
        end
    end

    // Character format register
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            character_format_register <= RST_CHAR_FORMAT;
        end else if (format_wr) begin
            character_format_register <= i_wdata;
        end
    end

    // Decoded format, registered so every output leaves a flip-flop
    assign next_len = format_wr ? i_wdata[CF_LEN_LO +: 2]
                                : character_format_register[CF_LEN_LO +: 2];
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_data_bits <= LEN_BASE + {2'h0, RST_CHAR_FORMAT[CF_LEN_LO +: 2]};
            o_stop <= UFL_STOP_ONE;
            o_parity_en <= 1'b0;
            o_parity <= UFL_PAR_ODD;
            o_bank_divisor <= 1'b0;
        end else begin
            o_data_bits <= LEN_BASE + {2'h0, character_format_register[CF_LEN_LO +: 2]};
            if (!character_format_register[CF_STOP]) begin
                o_stop <= UFL_STOP_ONE;
            end else if (character_format_register[CF_LEN_LO +: 2] == LEN_FIVE) begin
                o_stop <= UFL_STOP_ONE_HALF;
            end else begin
                o_stop <= UFL_STOP_TWO;
            end
            o_parity_en <= character_format_register[CF_PAR_EN];
            o_parity <= ufl_parity_t'(character_format_register[CF_PAR_LO +: 2]);
            o_bank_divisor <= character_format_register[CF_BANK];
        end
    end

    // Break overrides the transmitter; the raw stream keeps running underneath
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_txd <= ~LINE_SPACE;
        end else if (character_format_register[CF_BREAK]) begin
            o_txd <= LINE_SPACE;
        end else begin
            o_txd <= i_txd_raw;
        end
    end

    // Read port: only the format register answers here; setup is write-only
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
            o_rd_hit <= 1'b0;
        end else begin
            o_rd_hit <= i_rd && (i_addr == OFS_CHAR_FORMAT);
            o_rdata <= (i_rd && (i_addr == OFS_CHAR_FORMAT)) ? character_format_register : 8'h00;
        end
    end

    fifo_en_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fifo_wr |=> o_fifo_en == $past(i_wdata[FS_FIFO_EN]))
        else $error("fifo mode bit not written");
    rx_flush_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fifo_wr && i_wdata[FS_RX_FLUSH] |=> o_rx_flush)
        else $error("receive flush not raised");
    tx_flush_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_tx_flush && !tx_flush_req |=> !o_tx_flush)
        else $error("transmit flush raised without a write of one");
    tx_trig_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fifo_wr && i_wdata[5:4] == 2'h3 ##1 !fifo_wr |=> o_tx_trig == 7'h70)
        else $error("transmit trigger not 112");
    rx_trig_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        fifo_wr && i_wdata[7:6] == 2'h3 ##1 !fifo_wr && !i_enhanced
        |=> o_rx_trig == 7'h0e)
        else $error("receive trigger not 14");
    data_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        format_wr ##1 !format_wr |=> o_data_bits == 4'h5 + {2'h0, $past(next_len, 2)})
        else $error("data length decode wrong");
    break_line_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        character_format_register[CF_BREAK] |=> o_txd == 1'b0)
        else $error("line not held at space during break");
    bank_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        character_format_register[CF_BANK] && i_wr && i_addr == OFS_FIFO_SETUP
        |=> $stable(o_fifo_en))
        else $error("setup written while divisor bank selected");
    stop_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        character_format_register[2:0] == 3'h4 |=> o_stop == UFL_STOP_ONE_HALF)
        else $error("five bit characters need 1.5 stop bits");
endmodule // ufl_ctrl

// [hdl/ufl_pkg.sv]
package ufl_pkg;
    // Register window offsets
    localparam logic [2:0] OFS_FIFO_SETUP = 3'h2;
    localparam logic [2:0] OFS_CHAR_FORMAT = 3'h3;
    // Fifo setup register field positions
    localparam int FS_FIFO_EN = 0;
    localparam int FS_RX_FLUSH = 1;
    localparam int FS_TX_FLUSH = 2;
    localparam int FS_TX_TRIG_LO = 4;
    localparam int FS_RX_TRIG_LO = 6;
    // Character format register field positions
    localparam int CF_LEN_LO = 0;
    localparam int CF_STOP = 2;
    localparam int CF_PAR_EN = 3;
    localparam int CF_PAR_LO = 4;
    localparam int CF_BREAK = 6;
    localparam int CF_BANK = 7;
    // Values after reset
    localparam logic RST_FIFO_EN = 1'h0;
    localparam logic [1:0] RST_TX_TRIG = 2'h0;
    localparam logic [1:0] RST_RX_TRIG = 2'h0;
    localparam logic [7:0] RST_CHAR_FORMAT = 8'h03;
    // Data length code for five bits, the only length with 1.5 stop bits
    localparam logic [1:0] LEN_FIVE = 2'h0;
    localparam logic [3:0] LEN_BASE = 4'h5;
    // Parity selections when parity is on
    typedef enum logic [1:0] {
        UFL_PAR_ODD = 2'b00,
        UFL_PAR_EVEN = 2'b01,
        UFL_PAR_MARK = 2'b10,
        UFL_PAR_SPACE = 2'b11
    } ufl_parity_t;
    // Stop bit lengths on the line
    typedef enum logic [1:0] {
        UFL_STOP_ONE = 2'b00,
        UFL_STOP_ONE_HALF = 2'b01,
        UFL_STOP_TWO = 2'b10
    } ufl_stop_t;
    // Trigger thresholds in entries, indexed by the two-bit code
    localparam logic [6:0] TX_TRIG_ENH [4] = '{7'h10, 7'h20, 7'h40, 7'h70};
    localparam logic [6:0] RX_TRIG_STD [4] = '{7'h01, 7'h04, 7'h08, 7'h0e};
    localparam logic [6:0] RX_TRIG_ENH [4] = '{7'h0f, 7'h1f, 7'h3f, 7'h6f};
    // Break (space) level; the idle line is its inverse
    localparam logic LINE_SPACE = 1'h0;
endpackage

// [hdl/ufl_flush.sv]
`timescale 1ns/100ps
module ufl_flush (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Request from a register write, completion from the fifo
    input wire logic i_req,
    input wire logic i_done,
    // Flush command held until done
    output logic o_busy
);
    // A request landing with done re-arms the flush so it is not lost
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
        end else if (i_req) begin
            o_busy <= 1'b1;
        end else if (i_done) begin
            o_busy <= 1'b0;
        end
    end

    busy_clears_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_busy && i_done && !i_req |=> !o_busy)
        else $error("flush bit did not clear after done");
    req_sets_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_req |=> o_busy)
        else $error("flush request not taken");
endmodule // ufl_flush

// [dv/ufl_far_model.sv]
`timescale 1ns/100ps
// Fifo side: acknowledges a flush a few cycles late, never in the request cycle
module ufl_far_model #(
    parameter int FLUSH_CYCLES = 3
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Flush requests and completions
    input wire logic i_rx_flush,
    input wire logic i_tx_flush,
    output logic o_rx_done,
    output logic o_tx_done
);
    int rx_cnt;
    int tx_cnt;
    // Counters restart whenever the request drops
    always_ff @(posedge i_mclk) begin
        rx_cnt <= (!i_rst_n || !i_rx_flush) ? 0 : rx_cnt + 1;
        tx_cnt <= (!i_rst_n || !i_tx_flush) ? 0 : tx_cnt + 1;
    end
    // Done only while a flush is pending, so a stale done cannot clear a new one
    assign o_rx_done = i_rx_flush && (rx_cnt >= FLUSH_CYCLES);
    assign o_tx_done = i_tx_flush && (tx_cnt >= FLUSH_CYCLES);
endmodule // ufl_far_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import ufl_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [2:0] i_addr = 3'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_enhanced = 1'b0;
    logic i_txd_raw = 1'b1;
    logic i_rx_flush_done, i_tx_flush_done, o_rd_hit, o_fifo_en, o_rx_flush, o_tx_flush;
    logic o_parity_en, o_bank_divisor, o_txd;
    logic [7:0] o_rdata, cf;
    logic [6:0] o_tx_trig, o_rx_trig;
    logic [3:0] o_data_bits;
    ufl_stop_t o_stop;
    ufl_parity_t o_parity;
    int fails = 0;
    int comparisons = 0;
    // Expected thresholds, written out apart from the design's own tables
    logic [7:0] tx_tab [4] = '{8'h10, 8'h20, 8'h40, 8'h70};
    logic [7:0] rxs_tab [4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
    logic [7:0] rxe_tab [4] = '{8'h0f, 8'h1f, 8'h3f, 8'h6f};
    always #25 i_mclk = ~i_mclk;
    ufl_ctrl u_dut (.i_mclk, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_rd_hit,
        .i_enhanced, .i_rx_flush_done, .i_tx_flush_done, .o_fifo_en, .o_rx_flush, .o_tx_flush,
        .o_tx_trig, .o_rx_trig, .o_data_bits, .o_stop, .o_parity_en, .o_parity,
        .o_bank_divisor, .i_txd_raw, .o_txd);
    ufl_far_model u_far (.i_mclk, .i_rst_n, .i_rx_flush(o_rx_flush), .i_tx_flush(o_tx_flush),
        .o_rx_done(i_rx_flush_done), .o_tx_done(i_tx_flush_done));
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
            fails++;
        end
    endtask
    // A gap cycle before each strobe keeps back-to-back calls from re-driving it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(posedge i_mclk);
        #1;
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic hit, input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        i_addr = a;
        i_rd = 1'b1;
        @(posedge i_mclk);
        #1;
        i_rd = 1'b0;
        chk({7'h0, o_rd_hit}, {7'h0, hit});
        chk(o_rdata, d);
    endtask
    // Decoded outputs land on the edge after the write is taken
    task automatic settle();
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
    // Flush flag must rise at once, then self-clear within a bounded wait
    task automatic flush(input int b);
        logic seen;
        wr(OFS_FIFO_SETUP, 8'h01 << b);
        seen = (b == 1) ? o_rx_flush : o_tx_flush;
        chk({7'h0, seen}, 8'h01);
        for (int n = 0; n < 20 && seen === 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
            seen = (b == 1) ? o_rx_flush : o_tx_flush;
        end
        chk({7'h0, seen}, 8'h00);
        if (seen !== 1'b0) wrap_up();
    endtask
    initial begin
        repeat (6) @(posedge i_mclk);
        #1;
        i_rst_n = 1'b1;
        chk({o_fifo_en, o_bank_divisor, o_txd, o_parity_en, 2'(o_stop), 2'h0}, 8'h20);
        chk({1'b0, o_tx_trig}, 8'h10);
        chk({1'b0, o_rx_trig}, 8'h01);
        chk({4'h0, o_data_bits}, 8'h08);
        rd(OFS_CHAR_FORMAT, 1'b1, 8'h03);
        // Every trigger code in both modes, fifo mode on
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 4; k++) begin
                i_enhanced = e[0];
                wr(OFS_FIFO_SETUP, {k[1:0], k[1:0], 4'h1});
                settle();
                chk({5'h0, o_tx_flush, o_rx_flush, o_fifo_en}, 8'h01);
                chk({1'b0, o_tx_trig}, tx_tab[k]);
                chk({1'b0, o_rx_trig}, (e == 1) ? rxe_tab[k] : rxs_tab[k]);
            end
        end
        flush(1);
        flush(2);
        // Every length and parity code; five bits with the stop bit gives one and a half
        for (int k = 0; k < 4; k++) begin
            cf = {2'b00, k[1:0], 1'b1, ~k[0], k[1:0]};
            wr(OFS_CHAR_FORMAT, cf);
            settle();
            chk({4'h0, o_data_bits}, 8'h05 + k[7:0]);
            chk({5'h0, o_parity_en, 2'(o_parity)}, {5'h1, k[1:0]});
            chk({6'h0, 2'(o_stop)}, k[0] ? 8'h00 : ((k == 0) ? 8'h01 : 8'h02));
            rd(OFS_CHAR_FORMAT, 1'b1, cf);
        end
        // Break overrides an idle-high stream, then releases it
        wr(OFS_CHAR_FORMAT, 8'h43);
        settle();
        chk({7'h0, o_txd}, 8'h00);
        wr(OFS_CHAR_FORMAT, 8'h03);
        settle();
        chk({7'h0, o_txd}, 8'h01);
        // A low stream must pass once break is off, or a stuck-high line would go unseen
        i_txd_raw = 1'b0;
        settle();
        chk({7'h0, o_txd}, 8'h00);
        i_txd_raw = 1'b1;
        settle();
        chk({7'h0, o_txd}, 8'h01);
        // Divisor bank hides the setup register; setup stays unreadable
        wr(OFS_CHAR_FORMAT, 8'h83);
        wr(OFS_FIFO_SETUP, 8'h01);
        settle();
        chk({6'h0, o_bank_divisor, o_fifo_en}, 8'h02);
        rd(OFS_FIFO_SETUP, 1'b0, 8'h00);
        wr(OFS_CHAR_FORMAT, 8'h03);
        wr(OFS_FIFO_SETUP, 8'h01);
        settle();
        chk({6'h0, o_bank_divisor, o_fifo_en}, 8'h01);
        wrap_up();
    end
endmodule // tb_top
